// file: rtl/analog_io_defs.svh
// Object indices, sub-indices, field positions and reset values of the analog I/O objects
`ifndef ANALOG_IO_DEFS_SVH
`define ANALOG_IO_DEFS_SVH

// ----------------------------------------------------------------------------
// Object addresses
// ----------------------------------------------------------------------------
`define AIO_IDX_IN_CFG      16'h207b
`define AIO_IDX_IN_VOLT     16'h207c
`define AIO_IDX_MASK        16'h207d
`define AIO_IDX_OUT         16'h207e
`define AIO_SUB_ZERO        8'h00
`define AIO_SUB_ONE         8'h01
`define AIO_SUB_TWO         8'h02

// ----------------------------------------------------------------------------
// Field layout and codes
// ----------------------------------------------------------------------------
`define AIO_CFG_CURRENT     4'h0
`define AIO_CFG_VELOCITY    4'h1
`define AIO_CFG_POSITION    4'h2
`define AIO_CFG_GP_LOW      4'h8
`define AIO_CFG_MAX         16'h000f
`define AIO_MASK_CURRENT    0
`define AIO_MASK_VELOCITY   1
`define AIO_MASK_POSITION   2
`define AIO_MASK_USED       16'h0007

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define AIO_RST_CFG_ONE     16'h000f
`define AIO_RST_CFG_TWO     16'h000e
`define AIO_RST_MASK        16'h0000
`define AIO_RST_OUT_MV      16'h0000

`endif

// file: rtl/analog_io_pkg.sv
// Types shared by the analog I/O object bank
package analog_io_pkg;

    // ------------------------------------------------------------------------
    // Operating mode of the control function
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_CURRENT,
        MODE_VELOCITY,
        MODE_POSITION,
        MODE_OTHER
    } op_mode_t;

    // ------------------------------------------------------------------------
    // State of the object bank apart from the two converter captures
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [1:0]  rst_sync;
        logic [15:0] cfg_one;
        logic [15:0] cfg_two;
        logic [15:0] mask;
        logic [15:0] out_mv;
        logic        out_update;
        logic [15:0] rdata;
        logic        ack;
        logic        err;
    } bank_state_t;

endpackage : analog_io_pkg

// file: rtl/analog_sample_capture.sv
// Captures a converter word from another domain when its toggle flag changes
`timescale 1ns/10ps
module analog_sample_capture #(
    parameter int WIDTH = 16
) (
    // Clock and reset
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    // Converter side
    input  wire logic [WIDTH-1:0] sample_in,
    input  wire logic             sample_toggle_in,
    // Captured result
    output logic      [WIDTH-1:0] value_out
);

    typedef struct packed {
        logic [2:0]       tgl;
        logic [WIDTH-1:0] value;
    } cap_state_t;

    cap_state_t state_ff;
    cap_state_t nxt_state;

    // ------------------------------------------------------------------------
    // Toggle synchroniser and capture
    // ------------------------------------------------------------------------
    // The word is held stable by the converter while the toggle crosses, so
    // only the toggle needs the two-stage synchroniser; tgl[0] feeds tgl[1] only.
    always_comb begin
        nxt_state       = state_ff;
        nxt_state.tgl   = {state_ff.tgl[1:0], sample_toggle_in};
        if (state_ff.tgl[2] != state_ff.tgl[1]) begin
            nxt_state.value = sample_in;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign value_out = state_ff.value;

endmodule : analog_sample_capture

// file: rtl/analog_io_config_objects.sv
// Analog input/output parameter objects with setpoint routing
//
// Notes on behaviour
// - Object 0x207B/0x01 holds the functionality chosen for analog input one.
// - Object 0x207B/0x02 holds the functionality chosen for analog input two.
// - A configuration value names a bit of the functionality state word; 15 to 8 are readable general-purpose functions.
// - Value 2 makes the input the setpoint in position mode.
// - Value 1 makes the input the setpoint in velocity mode.
// - Value 0 makes the input the setpoint in current mode.
// - The mask at 0x207D/0x00 inhibits the current, velocity and position setpoints by bits 0, 1 and 2.
// - The measured voltage of input one reads at 0x207C/0x01.
// - The measured voltage of input two reads under the second input-value entry.
// - Object 0x207E/0x00 holds the millivolt level driven on the analog output.
// - Every write to the output object reaches the output at once with no commit step.
`timescale 1ns/10ps
`include "analog_io_defs.svh"
module analog_io_config_objects
    import analog_io_pkg::*;
#(
    parameter int VOLT_WIDTH = 16
) (
    // Clock and reset
    input  wire logic                  mclk_in,
    input  wire logic                  arst_n_in,
    // Object access port
    input  wire logic                  obj_req_in,
    input  wire logic                  obj_write_in,
    input  wire logic [15:0]           obj_index_in,
    input  wire logic [7:0]            obj_sub_in,
    input  wire logic [15:0]           obj_wdata_in,
    output logic      [15:0]           obj_rdata_out,
    output logic                       obj_ack_out,
    output logic                       obj_err_out,
    // Converter words from the analog front end
    input  wire logic [VOLT_WIDTH-1:0] analog_in_one_sample_in,
    input  wire logic                  analog_in_one_toggle_in,
    input  wire logic [VOLT_WIDTH-1:0] analog_in_two_sample_in,
    input  wire logic                  analog_in_two_toggle_in,
    // Control function side
    input  wire op_mode_t              op_mode_in,
    output logic      [VOLT_WIDTH-1:0] current_setpoint_out,
    output logic                       current_setpoint_valid_out,
    output logic      [VOLT_WIDTH-1:0] velocity_setpoint_out,
    output logic                       velocity_setpoint_valid_out,
    output logic      [VOLT_WIDTH-1:0] position_setpoint_out,
    output logic                       position_setpoint_valid_out,
    output logic      [15:0]           function_state_out,
    // Analog output
    output logic      [15:0]           analog_out_one_mv_out,
    output logic                       analog_out_one_update_out
);

    bank_state_t           state_ff;
    bank_state_t           nxt_state;
    logic                  rst_n;
    logic [VOLT_WIDTH-1:0] volt_one;
    logic [VOLT_WIDTH-1:0] volt_two;
    logic [15:0]           func_one;
    logic [15:0]           func_two;

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    // One-hot bit of the functionality state word; reserved codes give none
    function automatic logic [15:0] func_bit(input logic [15:0] cfg);
        logic [15:0] bits;
        bits = 16'h0000;
        if (cfg[3:0] <= `AIO_CFG_POSITION || cfg[3:0] >= `AIO_CFG_GP_LOW) begin
            bits[cfg[3:0]] = 1'b1;
        end
        return bits;
    endfunction : func_bit

    function automatic logic obj_hit(input logic [15:0] idx, input logic [7:0] sub);
        return (obj_index_in == idx) && (obj_sub_in == sub);
    endfunction : obj_hit

    // Configuration codes above the state word's top bit are refused
    function automatic logic code_fits(input logic [15:0] data);
        return data <= `AIO_CFG_MAX;
    endfunction : code_fits

    // ------------------------------------------------------------------------
    // Reset release and converter capture
    // ------------------------------------------------------------------------
    // Every register takes its reset value at once on the pin; only the synchroniser pair
    // decides when requests are honoured again, so release never races a request
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_ff <= '{cfg_one: `AIO_RST_CFG_ONE, cfg_two: `AIO_RST_CFG_TWO,
                          mask: `AIO_RST_MASK, out_mv: `AIO_RST_OUT_MV, default: '0};
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Released copy of reset for the captures and the request decode
    assign rst_n = state_ff.rst_sync[1];

    // One capture per input; each brings its converter word into this domain
    // on its own toggle, so the two inputs may be sampled at different rates
    analog_sample_capture #(
        .WIDTH            (VOLT_WIDTH)
    ) u_capture_one (
        .clk_in           (mclk_in),
        .rst_n_in         (rst_n),
        .sample_in        (analog_in_one_sample_in),
        .sample_toggle_in (analog_in_one_toggle_in),
        .value_out        (volt_one)
    );

    analog_sample_capture #(
        .WIDTH            (VOLT_WIDTH)
    ) u_capture_two (
        .clk_in           (mclk_in),
        .rst_n_in         (rst_n),
        .sample_in        (analog_in_two_sample_in),
        .sample_toggle_in (analog_in_two_toggle_in),
        .value_out        (volt_two)
    );

    // ------------------------------------------------------------------------
    // Object access
    // ------------------------------------------------------------------------
    // Answers come one edge after the request; unknown objects, writes to
    // read-only objects and out-of-range codes answer with an error.
    always_comb begin
        nxt_state            = state_ff;
        nxt_state.rst_sync   = {state_ff.rst_sync[0], 1'b1};
        nxt_state.ack        = 1'b0;
        nxt_state.err        = 1'b0;
        nxt_state.out_update = 1'b0;
        if (!rst_n) begin
            // Requests seen before the release completes get no answer
            nxt_state.rst_sync = {state_ff.rst_sync[0], 1'b1};
        end else if (obj_req_in) begin
            nxt_state.ack = 1'b1;
            if (obj_hit(`AIO_IDX_IN_CFG, `AIO_SUB_ONE)) begin
                if (obj_write_in) begin
                    if (code_fits(obj_wdata_in)) begin
                        nxt_state.cfg_one = obj_wdata_in;
                    end else begin
                        nxt_state.err = 1'b1;
                    end
                end else begin
                    nxt_state.rdata = state_ff.cfg_one;
                end
            end else if (obj_hit(`AIO_IDX_IN_CFG, `AIO_SUB_TWO)) begin
                if (obj_write_in) begin
                    if (code_fits(obj_wdata_in)) begin
                        nxt_state.cfg_two = obj_wdata_in;
                    end else begin
                        nxt_state.err = 1'b1;
                    end
                end else begin
                    nxt_state.rdata = state_ff.cfg_two;
                end
            end else if (obj_hit(`AIO_IDX_IN_VOLT, `AIO_SUB_ONE)) begin
                // Measured voltages are read-only: a write is refused, rdata left alone
                nxt_state.err   = obj_write_in;
                nxt_state.rdata = obj_write_in ? state_ff.rdata : 16'(volt_one);
            end else if (obj_hit(`AIO_IDX_IN_VOLT, `AIO_SUB_TWO)) begin
                nxt_state.err   = obj_write_in;
                nxt_state.rdata = obj_write_in ? state_ff.rdata : 16'(volt_two);
            end else if (obj_hit(`AIO_IDX_MASK, `AIO_SUB_ZERO)) begin
                // Reserved mask bits are not stored and read as zero
                if (obj_write_in) begin
                    nxt_state.mask = obj_wdata_in & `AIO_MASK_USED;
                end else begin
                    nxt_state.rdata = state_ff.mask;
                end
            end else if (obj_hit(`AIO_IDX_OUT, `AIO_SUB_ZERO)) begin
                if (obj_write_in) begin
                    nxt_state.out_mv     = obj_wdata_in;
                    nxt_state.out_update = 1'b1;
                end else begin
                    nxt_state.rdata = state_ff.out_mv;
                end
            end else begin
                nxt_state.err = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Setpoint routing
    // ------------------------------------------------------------------------
    // Setpoints are muxes of registered words, so they settle right after the
    // edge; the control function must register them before use
    // Input one wins when both inputs claim the same setpoint
    assign func_one = func_bit(state_ff.cfg_one);
    assign func_two = func_bit(state_ff.cfg_two);
    // Reserved codes contribute no bit, so the word shows only real assignments
    assign function_state_out = func_one | func_two;

    assign current_setpoint_out  = func_one[`AIO_CFG_CURRENT] ? volt_one : volt_two;
    assign velocity_setpoint_out = func_one[`AIO_CFG_VELOCITY] ? volt_one : volt_two;
    assign position_setpoint_out = func_one[`AIO_CFG_POSITION] ? volt_one : volt_two;

    // A setpoint is live only when assigned, not masked, and in its mode
    assign current_setpoint_valid_out = (op_mode_in == MODE_CURRENT)
        && function_state_out[`AIO_CFG_CURRENT]
        && !state_ff.mask[`AIO_MASK_CURRENT];
    assign velocity_setpoint_valid_out = (op_mode_in == MODE_VELOCITY)
        && function_state_out[`AIO_CFG_VELOCITY]
        && !state_ff.mask[`AIO_MASK_VELOCITY];
    assign position_setpoint_valid_out = (op_mode_in == MODE_POSITION)
        && function_state_out[`AIO_CFG_POSITION]
        && !state_ff.mask[`AIO_MASK_POSITION];

    // ------------------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------------------
    // Answer, read data and output level leave straight from registers
    assign obj_rdata_out             = state_ff.rdata;
    assign obj_ack_out               = state_ff.ack;
    assign obj_err_out               = state_ff.err;
    assign analog_out_one_mv_out     = state_ff.out_mv;
    assign analog_out_one_update_out = state_ff.out_update;

endmodule : analog_io_config_objects

// file: testbench/analog_io_checker_sva.sv
// Checker for the object port, analog output and setpoint outputs of the analog I/O bank
`timescale 1ns/10ps
module analog_io_checker_sva
    import analog_io_pkg::*;
(
    // Clock and reset
    input wire logic        mclk_in,
    input wire logic        arst_n_in,
    // Object port
    input wire logic        obj_req_in,
    input wire logic        obj_write_in,
    input wire logic [15:0] obj_index_in,
    input wire logic [7:0]  obj_sub_in,
    input wire logic [15:0] obj_wdata_in,
    input wire logic        obj_ack_out,
    input wire logic        obj_err_out,
    // Control side and analog output
    input wire op_mode_t    op_mode_in,
    input wire logic        current_setpoint_valid_out,
    input wire logic        velocity_setpoint_valid_out,
    input wire logic        position_setpoint_valid_out,
    input wire logic [15:0] analog_out_one_mv_out,
    input wire logic        analog_out_one_update_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!arst_n_in);

    // Write decodes, kept as nets so the properties stay short
    wire wr_any = obj_req_in && obj_write_in;
    wire wr_out = wr_any && obj_index_in == 16'h207e && obj_sub_in == 8'h00;

    // -------------------------------------------------------------------------
    // Properties
    // -------------------------------------------------------------------------
    a_req_acked: assert property (obj_req_in |=> obj_ack_out)
        else $error("request not answered on next edge");
    a_ack_caused: assert property (obj_ack_out |-> $past(obj_req_in))
        else $error("answer without request");
    a_err_paired: assert property (obj_err_out |-> obj_ack_out)
        else $error("error without answer");
    a_out_now: assert property (wr_out |=> analog_out_one_update_out
        && analog_out_one_mv_out == $past(obj_wdata_in)) else $error("output write late");
    a_out_holds: assert property (!analog_out_one_update_out
        |-> $stable(analog_out_one_mv_out)) else $error("output level moved");
    a_volt_readonly: assert property (wr_any && obj_index_in == 16'h207c
        |=> obj_err_out) else $error("voltage write accepted");
    a_cfg_range: assert property (wr_any && obj_index_in == 16'h207b
        && obj_wdata_in > 16'h000f |=> obj_err_out) else $error("bad code accepted");
    a_cur_mode: assert property (current_setpoint_valid_out
        |-> op_mode_in == MODE_CURRENT) else $error("current setpoint out of mode");
    a_vel_mode: assert property (velocity_setpoint_valid_out
        |-> op_mode_in == MODE_VELOCITY) else $error("velocity setpoint out of mode");
    a_pos_mode: assert property (position_setpoint_valid_out
        |-> op_mode_in == MODE_POSITION) else $error("position setpoint out of mode");
endmodule : analog_io_checker_sva

bind analog_io_config_objects analog_io_checker_sva u_chk (
    .mclk_in(mclk_in), .arst_n_in(arst_n_in), .obj_req_in(obj_req_in),
    .obj_write_in(obj_write_in), .obj_index_in(obj_index_in), .obj_sub_in(obj_sub_in),
    .obj_wdata_in(obj_wdata_in), .obj_ack_out(obj_ack_out), .obj_err_out(obj_err_out),
    .op_mode_in(op_mode_in), .current_setpoint_valid_out(current_setpoint_valid_out),
    .velocity_setpoint_valid_out(velocity_setpoint_valid_out),
    .position_setpoint_valid_out(position_setpoint_valid_out),
    .analog_out_one_mv_out(analog_out_one_mv_out),
    .analog_out_one_update_out(analog_out_one_update_out));

// file: testbench/analog_io_config_objects_tb.sv
// Self-checking bench for the analog I/O object bank
`timescale 1ns/10ps
module analog_io_config_objects_tb
    import analog_io_pkg::*;
;
    logic        mclk_in = 1'b0, arst_n_in = 1'b0, req = 1'b0, wr = 1'b0;
    logic        tog1 = 1'b0, tog2 = 1'b0, ack, err, upd, g_err;
    logic [15:0] idx = 16'h0, wd = 16'h0, smp1 = 16'h0, smp2 = 16'h0, rd, st, mv, g_rd;
    logic [7:0]  sub = 8'h0;
    wire  [2:0]  vld;
    wire  [47:0] spt;
    op_mode_t    mode = MODE_OTHER;
    int          fail_count = 0, checked = 0;

    analog_io_config_objects dut (.mclk_in(mclk_in), .arst_n_in(arst_n_in),
        .obj_req_in(req), .obj_write_in(wr), .obj_index_in(idx), .obj_sub_in(sub),
        .obj_wdata_in(wd), .obj_rdata_out(rd), .obj_ack_out(ack), .obj_err_out(err),
        .analog_in_one_sample_in(smp1), .analog_in_one_toggle_in(tog1),
        .analog_in_two_sample_in(smp2), .analog_in_two_toggle_in(tog2),
        .op_mode_in(mode), .current_setpoint_out(spt[15:0]),
        .current_setpoint_valid_out(vld[0]), .velocity_setpoint_out(spt[31:16]),
        .velocity_setpoint_valid_out(vld[1]), .position_setpoint_out(spt[47:32]),
        .position_setpoint_valid_out(vld[2]), .function_state_out(st),
        .analog_out_one_mv_out(mv), .analog_out_one_update_out(upd));

    // Clock at 50 MHz
    initial begin
        forever #10 mclk_in = ~mclk_in;
    end

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // One object access; ack, err and read data are taken at the falling edge
    // right after the taking edge, in the middle of the one cycle in which the pulses stand
    task automatic acc(input logic w, input logic [15:0] i, input logic [7:0] s,
                       input logic [15:0] d);
        @(negedge mclk_in);
        req = 1'b1;
        wr = w;
        idx = i;
        sub = s;
        wd = d;
        @(negedge mclk_in);
        chk("ack", 16'h0001, {15'h0, ack});
        g_rd = rd;
        g_err = err;
        req = 1'b0;
    endtask : acc

    task automatic s_reset();
        acc(1'b0, 16'h207b, 8'h01, 16'h0);
        chk("cfg_one", 16'h000f, g_rd);
        acc(1'b0, 16'h207b, 8'h02, 16'h0);
        chk("cfg_two", 16'h000e, g_rd);
        acc(1'b0, 16'h207d, 8'h00, 16'h0);
        chk("mask", 16'h0000, g_rd);
        chk("state", 16'hc000, st);
    endtask : s_reset

    // Words are held long after the toggle so the capture sees them settled
    task automatic s_volt();
        @(negedge mclk_in);
        smp1 = 16'h1234;
        smp2 = 16'h0abc;
        tog1 = ~tog1;
        tog2 = ~tog2;
        repeat (5) @(negedge mclk_in);
        acc(1'b0, 16'h207c, 8'h01, 16'h0);
        chk("volt_one", 16'h1234, g_rd);
        acc(1'b0, 16'h207c, 8'h02, 16'h0);
        chk("volt_two", 16'h0abc, g_rd);
        acc(1'b1, 16'h207c, 8'h01, 16'hffff);
        chk("volt_wr_err", 16'h0001, {15'h0, g_err});
        chk("volt_wr_rd", 16'h0abc, g_rd);
    endtask : s_volt

    task automatic s_out();
        acc(1'b1, 16'h207e, 8'h00, 16'h1388);
        chk("update", 16'h0001, {15'h0, upd});
        chk("mv", 16'h1388, mv);
        @(negedge mclk_in);
        chk("update_end", 16'h0000, {15'h0, upd});
        acc(1'b0, 16'h207e, 8'h00, 16'h0);
        chk("mv_read", 16'h1388, g_rd);
    endtask : s_out

    // Input two parked on a reserved code so input one alone drives the setpoints
    task automatic s_setpt();
        acc(1'b1, 16'h207b, 8'h02, 16'h0003);
        for (int k = 0; k < 3; k++) begin
            acc(1'b1, 16'h207b, 8'h01, 16'(k));
            mode = op_mode_t'(k);
            @(negedge mclk_in);
            chk("valid", 16'h0001 << k, {13'h0, vld});
            chk("setpoint", 16'h1234, spt[16*k +: 16]);
            chk("state_k", 16'h0001 << k, st);
            acc(1'b1, 16'h207d, 8'h00, 16'h0001 << k);
            chk("masked", 16'h0000, {13'h0, vld});
            acc(1'b1, 16'h207d, 8'h00, 16'h0);
        end
        acc(1'b1, 16'h207b, 8'h01, 16'h0004);
        chk("rsv_valid", 16'h0000, {13'h0, vld});
        chk("rsv_state", 16'h0000, st);
        acc(1'b1, 16'h207b, 8'h01, 16'h0010);
        chk("big_err", 16'h0001, {15'h0, g_err});
        acc(1'b0, 16'h207b, 8'h01, 16'h0);
        chk("cfg_kept", 16'h0004, g_rd);
    endtask : s_setpt

    // Input two as a setpoint source, input one winning, refusals, mid-run reset
    task automatic s_misc();
        acc(1'b1, 16'h207b, 8'h01, 16'h0008);
        acc(1'b1, 16'h207b, 8'h02, 16'h0001);
        mode = MODE_VELOCITY;
        @(negedge mclk_in);
        chk("two_valid", 16'h0002, {13'h0, vld});
        chk("two_setpoint", 16'h0abc, spt[31:16]);
        chk("gp_state", 16'h0102, st);
        mode = MODE_OTHER;
        @(negedge mclk_in);
        chk("other_valid", 16'h0000, {13'h0, vld});
        acc(1'b1, 16'h207b, 8'h01, 16'h0001);
        chk("one_wins", 16'h1234, spt[31:16]);
        acc(1'b1, 16'h207d, 8'h00, 16'hffff);
        acc(1'b0, 16'h207d, 8'h00, 16'h0);
        chk("mask_used", 16'h0007, g_rd);
        acc(1'b0, 16'h2000, 8'h00, 16'h0);
        chk("unknown_err", 16'h0001, {15'h0, g_err});
        @(negedge mclk_in);
        arst_n_in = 1'b0;
        @(negedge mclk_in);
        chk("rst_mv", 16'h0000, mv);
        arst_n_in = 1'b1;
        repeat (3) @(negedge mclk_in);
        s_reset();
    endtask : s_misc

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_of_test

    // Watchdog: the whole sequence needs well under a thousand cycles
    initial begin
        repeat (3000) @(posedge mclk_in);
        fail_count++;
        end_of_test();
    end

    // Main sequence
    initial begin
        repeat (4) @(negedge mclk_in);
        arst_n_in = 1'b1;
        repeat (3) @(negedge mclk_in);
        s_reset();
        s_volt();
        s_out();
        s_setpt();
        s_misc();
        end_of_test();
    end
endmodule : analog_io_config_objects_tb
